/* verilog/mpec_pkg.sv */
package mpec_pkg;

    // register offsets from the io window base
    localparam logic [2:0] PortAPinLevelOff    = 3'h2;
    localparam logic [2:0] PortBPinLevelOff    = 3'h3;
    localparam logic [2:0] PortADirectionOff   = 3'h4;
    localparam logic [2:0] PortBDirectionOff   = 3'h5;
    localparam logic [2:0] PortAOutputLatchOff = 3'h6;
    localparam logic [2:0] PortBOutputLatchOff = 3'h7;
    localparam logic [7:0] DirectionReset      = 8'h00;
    localparam logic [7:0] OutputLatchReset    = 8'h00;

    // controller's own avalon registers (byte addresses)
    localparam logic [3:0] CmdAddrOff    = 4'h0;
    localparam logic [3:0] CmdDataOff    = 4'h4;
    localparam logic [3:0] StatusOff     = 4'h8;
    localparam logic [3:0] ReadDataOff   = 4'hc;
    localparam int         CmdGoBit      = 8;
    localparam int         CmdWriteBit   = 9;
    localparam int         CmdResetBit   = 10;
    localparam int         CmdPowerBit   = 11;

    // strobe timing
    localparam int ClockMhz           = 40;
    localparam int ResetHoldNs        = 500;
    localparam int ResetRecoverNs     = 500;
    localparam int StrobeLowNs        = 100;
    localparam int SetupNs            = 50;
    localparam int ResetHoldCycles    = (ResetHoldNs * ClockMhz + 999) / 1000;
    localparam int ResetRecoverCycles = (ResetRecoverNs * ClockMhz + 999)
                                        / 1000;
    localparam int StrobeLowCycles    = (StrobeLowNs * ClockMhz + 999) / 1000;
    localparam int SetupCycles        = (SetupNs * ClockMhz + 999) / 1000;
    localparam int CountWidth         = 8;

    typedef enum logic [2:0] {
        MPEC_IDLE    = 3'b000,
        MPEC_RESET   = 3'b001,
        MPEC_RECOVER = 3'b010,
        MPEC_SETUP   = 3'b011,
        MPEC_STROBE  = 3'b100,
        MPEC_HOLD    = 3'b101
    } mpec_state_type;

    // host-side bus pins toward the device
    typedef struct packed {
        logic [7:0] address;
        logic       ioWindowSelect;
        logic       dataStrobeN;
        logic       readNotWrite;
        logic       deviceResetN;
        logic       powerDownOrAddr19;
        logic [7:0] dataOut;
        logic       dataOe;
    } mpec_bus_type;

endpackage : mpec_pkg

/* verilog/mpec_host_ctrl.sv */
`timescale 1ns/10ps
// Notes on behaviour
// - strobe reads when direction high, else writes
// - reset asynchronous, held at least 100 ns
// - low-voltage: 500 ns low, 500 ns recovery
// - system applies explicit reset after power-up
module mpec_host_ctrl (
    input  wire logic                  sys_clk,
    input  wire logic                  reset,
    input  wire logic [3:0]            avsAddress,
    input  wire logic                  avsRead,
    input  wire logic                  avsWrite,
    input  wire logic [31:0]           avsWriteData,
    output logic      [31:0]           avsReadData,
    output logic                       avsWaitRequest,
    output mpec_pkg::mpec_bus_type     busOut,
    input  wire logic [7:0]            busDataIn
);

    mpec_pkg::mpec_state_type state_q, state_d;
    logic [mpec_pkg::CountWidth-1:0] count_q, count_d;
    logic [2:0] offset_q, offset_d;
    logic [7:0] wdata_q, wdata_d;
    logic [7:0] rdata_q, rdata_d;
    logic       isWrite_q, isWrite_d;
    logic       powerDown_q, powerDown_d;
    logic       busy_q, busy_d;
    logic       ready_q, ready_d;
    logic       error_q, error_d;
    logic [31:0] avsReadData_d;
    logic        regAccess;

    // avalon slave answers after one wait cycle, register data stable
    assign regAccess      = avsRead | avsWrite;
    assign avsWaitRequest = regAccess & ~ready_q;

    always_comb begin
        state_d     = state_q;
        count_d     = count_q;
        offset_d    = offset_q;
        wdata_d     = wdata_q;
        rdata_d     = rdata_q;
        isWrite_d   = isWrite_q;
        powerDown_d = powerDown_q;
        busy_d      = busy_q;
        error_d     = error_q;
        ready_d     = regAccess & ~ready_q;
        avsReadData_d = 32'h0;
        if (avsRead) begin
            if (avsAddress == mpec_pkg::CmdAddrOff) begin
                avsReadData_d = {29'h0, offset_q};
                avsReadData_d[mpec_pkg::CmdPowerBit] = powerDown_q;
            end else if (avsAddress == mpec_pkg::CmdDataOff) begin
                avsReadData_d = {24'h0, wdata_q};
            end else if (avsAddress == mpec_pkg::StatusOff) begin
                avsReadData_d = {29'h0, error_q, state_q == mpec_pkg::MPEC_IDLE,
                                 busy_q};
            end else if (avsAddress == mpec_pkg::ReadDataOff) begin
                avsReadData_d = {24'h0, rdata_q};
            end else begin
                avsReadData_d = 32'h0;
            end
        end
        // a write lands only at the edge that shows waitrequest low
        if (avsWrite && ready_q) begin
            if (avsAddress == mpec_pkg::CmdDataOff) begin
                wdata_d = avsWriteData[7:0];
            end else if (avsAddress == mpec_pkg::CmdAddrOff) begin
                offset_d    = avsWriteData[2:0];
                powerDown_d = avsWriteData[mpec_pkg::CmdPowerBit];
                if (avsWriteData[mpec_pkg::CmdResetBit] && !busy_q) begin
                    busy_d  = 1'b1;
                    error_d = 1'b0;
                    count_d = '0;
                    state_d = mpec_pkg::MPEC_RESET;
                end else if (avsWriteData[mpec_pkg::CmdGoBit] && !busy_q) begin
                    isWrite_d = avsWriteData[mpec_pkg::CmdWriteBit];
                    // pin-level registers refuse writes
                    if (avsWriteData[mpec_pkg::CmdWriteBit] &&
                        (avsWriteData[2:0] == mpec_pkg::PortAPinLevelOff ||
                         avsWriteData[2:0] == mpec_pkg::PortBPinLevelOff))
                    begin
                        error_d = 1'b1;
                    end else begin
                        busy_d  = 1'b1;
                        error_d = 1'b0;
                        count_d = '0;
                        state_d = mpec_pkg::MPEC_SETUP;
                    end
                end
            end
        end
        case (state_q)
            mpec_pkg::MPEC_IDLE: begin
            end
            mpec_pkg::MPEC_RESET: begin
                count_d = count_q + 1'b1;
                // 500 ns covers both the 100 ns and low-voltage minimums
                if (count_q == mpec_pkg::CountWidth'(
                        mpec_pkg::ResetHoldCycles - 1)) begin
                    count_d = '0;
                    state_d = mpec_pkg::MPEC_RECOVER;
                end
            end
            mpec_pkg::MPEC_RECOVER: begin
                count_d = count_q + 1'b1;
                if (count_q == mpec_pkg::CountWidth'(
                        mpec_pkg::ResetRecoverCycles - 1)) begin
                    busy_d  = 1'b0;
                    state_d = mpec_pkg::MPEC_IDLE;
                end
            end
            mpec_pkg::MPEC_SETUP: begin
                count_d = count_q + 1'b1;
                if (count_q == mpec_pkg::CountWidth'(
                        mpec_pkg::SetupCycles - 1)) begin
                    count_d = '0;
                    state_d = mpec_pkg::MPEC_STROBE;
                end
            end
            mpec_pkg::MPEC_STROBE: begin
                count_d = count_q + 1'b1;
                if (count_q == mpec_pkg::CountWidth'(
                        mpec_pkg::StrobeLowCycles - 1)) begin
                    // read data sampled just before the strobe rises
                    if (!isWrite_q) begin
                        rdata_d = busDataIn;
                    end
                    count_d = '0;
                    state_d = mpec_pkg::MPEC_HOLD;
                end
            end
            mpec_pkg::MPEC_HOLD: begin
                count_d = count_q + 1'b1;
                if (count_q == mpec_pkg::CountWidth'(
                        mpec_pkg::SetupCycles - 1)) begin
                    busy_d  = 1'b0;
                    state_d = mpec_pkg::MPEC_IDLE;
                end
            end
            default: begin
                state_d = mpec_pkg::MPEC_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_q     <= mpec_pkg::MPEC_IDLE;
            count_q     <= '0;
            offset_q    <= 3'h0;
            wdata_q     <= 8'h00;
            rdata_q     <= 8'h00;
            isWrite_q   <= 1'b0;
            powerDown_q <= 1'b0;
            busy_q      <= 1'b0;
            ready_q     <= 1'b0;
            error_q     <= 1'b0;
            avsReadData <= 32'h0;
        end else begin
            state_q     <= state_d;
            count_q     <= count_d;
            offset_q    <= offset_d;
            wdata_q     <= wdata_d;
            rdata_q     <= rdata_d;
            isWrite_q   <= isWrite_d;
            powerDown_q <= powerDown_d;
            busy_q      <= busy_d;
            ready_q     <= ready_d;
            error_q     <= error_d;
            avsReadData <= avsReadData_d;
        end
    end

    // bus pins: direction stands through setup, strobe, hold; address is offset_q, which a CmdAddrOff write changes even while busy
    always_comb begin
        busOut.address           = {5'h0, offset_q};
        busOut.ioWindowSelect    = (state_q == mpec_pkg::MPEC_SETUP) ||
                                   (state_q == mpec_pkg::MPEC_STROBE) ||
                                   (state_q == mpec_pkg::MPEC_HOLD);
        busOut.readNotWrite      = ~isWrite_q;
        busOut.dataStrobeN       = ~(state_q == mpec_pkg::MPEC_STROBE);
        busOut.deviceResetN      = ~(state_q == mpec_pkg::MPEC_RESET);
        busOut.powerDownOrAddr19 = powerDown_q;
        busOut.dataOut           = wdata_q;
        // data held past the strobe's rising edge into hold
        busOut.dataOe            = isWrite_q &&
                                   ((state_q == mpec_pkg::MPEC_STROBE) ||
                                    (state_q == mpec_pkg::MPEC_HOLD));
    end

endmodule : mpec_host_ctrl

/* dv/mpec_host_ctrl_props.sv */
`timescale 1ns/10ps
module mpec_host_ctrl_props (
    input wire logic                   sys_clk,
    input wire logic                   reset,
    input wire logic                   avsRead,
    input wire logic                   avsWrite,
    input wire logic                   avsWaitRequest,
    input wire mpec_pkg::mpec_bus_type busOut
);
    logic [7:0] lowCnt_q;
    logic [7:0] lowCnt_d;
    always_comb lowCnt_d = busOut.deviceResetN ? 8'h00 : lowCnt_q + 8'h01;
    always_ff @(posedge sys_clk) lowCnt_q <= reset ? 8'h00 : lowCnt_d;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    strobe_window_a: assert property (!busOut.dataStrobeN |->
        busOut.ioWindowSelect && busOut.deviceResetN) else $error("strobe");
    strobe_width_a: assert property ($fell(busOut.dataStrobeN) |->
        !busOut.dataStrobeN[*4] ##1 busOut.dataStrobeN) else $error("width");
    write_drive_a: assert property (!busOut.dataStrobeN
        && !busOut.readNotWrite |-> busOut.dataOe) else $error("drive");
    read_float_a: assert property (busOut.dataOe
        |-> !busOut.readNotWrite) else $error("read drive");
    dir_stable_a: assert property (!busOut.dataStrobeN |->
        $stable(busOut.readNotWrite) && $stable(busOut.address))
        else $error("direction moved");
    write_hold_a: assert property ($rose(busOut.dataStrobeN)
        && !busOut.readNotWrite |-> busOut.dataOe) else $error("hold");
    reset_width_a: assert property ($rose(busOut.deviceResetN)
        |-> lowCnt_q >= 8'h14) else $error("reset short");
    wait_first_a: assert property ((avsRead || avsWrite)
        && avsWaitRequest |=> !avsWaitRequest) else $error("wait");
endmodule : mpec_host_ctrl_props
bind mpec_host_ctrl mpec_host_ctrl_props mpec_host_ctrl_props_inst (
    .sys_clk, .reset, .avsRead, .avsWrite, .avsWaitRequest, .busOut);

/* dv/mpec_device_model.sv */
`timescale 1ns/10ps
module mpec_device_model (
    input wire mpec_pkg::mpec_bus_type busOut,
    input wire logic [7:0]             extPins,
    output logic     [7:0]             busDataIn
);
    logic [7:0] regs_q [4:7];
    logic [7:0] pinLevel;
    logic [7:0] rdByte;
    logic       b;
    logic       live;
    // both ports see the same outside levels to keep the model small
    assign b = busOut.address[0];
    assign live = busOut.deviceResetN && !busOut.powerDownOrAddr19;
    assign pinLevel = (regs_q[{2'b10, b}] & regs_q[{2'b11, b}])
                    | (~regs_q[{2'b10, b}] & extPins);
    assign rdByte = busOut.address[2] ? regs_q[busOut.address[2:0]]
                  : pinLevel;
    // a released bus shows the inverse, never a stale copy
    assign busDataIn = (!busOut.dataStrobeN && busOut.readNotWrite
        && busOut.ioWindowSelect && live) ? rdByte : ~rdByte;
    always @(negedge busOut.deviceResetN or posedge busOut.dataStrobeN) begin
        if (!busOut.deviceResetN) begin
            regs_q <= '{default: 8'h00};
        end else if (live && busOut.ioWindowSelect && !busOut.readNotWrite
                     && busOut.address[2]) begin
            regs_q[busOut.address[2:0]] <= busOut.dataOut;
        end
    end
endmodule : mpec_device_model

/* dv/mpec_host_ctrl_tb.sv */
`timescale 1ns/10ps
module mpec_host_ctrl_tb;
    logic        sys_clk = 1'b0;
    logic        reset = 1'b1;
    logic [3:0]  avsAddress = 4'h0;
    logic        avsRead = 1'b0;
    logic        avsWrite = 1'b0;
    logic [31:0] avsWriteData = 32'h0;
    logic [31:0] avsReadData;
    logic        avsWaitRequest;
    logic [7:0]  busDataIn;
    logic [7:0]  extPins = 8'h00;
    logic [7:0]  shadow [4:7];
    logic [31:0] q;
    logic [2:0]  o;
    logic [7:0]  d;
    logic        pwr = 1'b0;
    int          bad_count = 0;
    int          samples_checked = 0;
    mpec_pkg::mpec_bus_type busOut;
    always #12.5 sys_clk = ~sys_clk;
    mpec_host_ctrl mpec_host_ctrl_inst (.sys_clk, .reset, .avsAddress,
        .avsRead, .avsWrite, .avsWriteData, .avsReadData, .avsWaitRequest,
        .busOut, .busDataIn);
    mpec_device_model mpec_device_model_inst (.busOut, .extPins, .busDataIn);
    task automatic print_verdict();
        if (bad_count == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : print_verdict
    task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", w, e, g);
        end
    endtask : chk
    task automatic avm(input logic [3:0] a, input logic wr, input logic [31:0] v);
        int n;
        n = 0;
        avsAddress <= a;
        avsWrite <= wr;
        avsRead <= !wr;
        avsWriteData <= v;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avsWaitRequest !== 1'b0 && n < 40);
        q = avsReadData;
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
        if (avsWaitRequest !== 1'b0) begin
            bad_count++;
            print_verdict();
        end
        @(posedge sys_clk);
    endtask : avm
    task automatic dev(input logic [2:0] f, input logic wr, input logic [7:0] v,
                       input logic rst);
        int n;
        n = 0;
        avm(mpec_pkg::CmdDataOff, 1'b1, {24'h0, v});
        avm(mpec_pkg::CmdAddrOff, 1'b1,
            {20'h0, pwr, rst, wr, !rst, 5'h0, f});
        do begin
            avm(mpec_pkg::StatusOff, 1'b0, 32'h0);
            n++;
        end while (q[0] !== 1'b0 && n < 40);
        if (q[0] !== 1'b0) begin
            bad_count++;
            print_verdict();
        end
        if (!wr && !rst) avm(mpec_pkg::ReadDataOff, 1'b0, 32'h0);
    endtask : dev
    function automatic logic [7:0] pinExp(input logic p);
        return (shadow[{2'b10, p}] & shadow[{2'b11, p}])
             | (~shadow[{2'b10, p}] & extPins);
    endfunction : pinExp
    task automatic checkAll();
        for (int i = 2; i < 8; i++) begin
            dev(i[2:0], 1'b0, 8'h00, 1'b0);
            chk("port reg", {24'h0, (i < 4) ? pinExp(i[0]) : shadow[i]}, q);
        end
    endtask : checkAll
    initial begin
        void'($urandom(32'hd58638e3));
        repeat (12) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        dev(3'h0, 1'b0, 8'h00, 1'b1);
        shadow = '{default: 8'h00};
        checkAll();
        repeat (16) begin
            o = 3'h4 + 3'($urandom_range(3));
            d = 8'($urandom);
            extPins <= 8'($urandom);
            dev(o, 1'b1, d, 1'b0);
            shadow[o] = d;
            checkAll();
        end
        dev(3'h2, 1'b1, 8'h5a, 1'b0);
        chk("error flag", 32'h1, {31'h0, q[2]});
        avm(4'h2, 1'b0, 32'h0);
        chk("unmapped", 32'h0, q);
        pwr = 1'b1;
        dev(3'h6, 1'b1, ~shadow[6], 1'b0);
        pwr = 1'b0;
        checkAll();
        dev(3'h0, 1'b0, 8'h00, 1'b1);
        shadow = '{default: 8'h00};
        checkAll();
        print_verdict();
    end
endmodule : mpec_host_ctrl_tb
